/* core/usw_switch_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module usw_switch_ctrl
  import usw_pkg::*;
#(
  parameter bit FACTORY_ACTIVE_LOW = 1'b1
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_attach_pulse,
  input  wire logic       i_detach_pulse,
  input  wire logic [1:0] i_auto_minus_sel,
  input  wire logic [1:0] i_auto_plus_sel,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic            o_usb_path_minus_en,
  output logic            o_uart_path_minus_en,
  output logic            o_usb_path_plus_en,
  output logic            o_uart_path_plus_en,
  output logic            o_boot_level,
  output logic            o_factory_mode_output,
  output logic            o_factory_mode_output_oe,
  output logic            o_soft_reset
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  initial begin
    if (FACTORY_ACTIVE_LOW !== 1'b0 && FACTORY_ACTIVE_LOW !== 1'b1) begin
      $error("bad variant");
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] control_q, control_d;
  logic [7:0] routing_q, routing_d;
  logic [7:0] bootfact_q, bootfact_d;
  logic       attached_q, attached_d;
  logic       srst_q, srst_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       wr_hit_reset;

  assign wr_hit_reset = i_wr_en && (i_addr == ADDR_SRESET) && i_wdata[SRST_BIT];

  always_comb begin
    control_d  = control_q;
    routing_d  = routing_q;
    bootfact_d = bootfact_q;
    if (i_wr_en) begin
      case (i_addr)
        ADDR_CONTROL:  control_d  = i_wdata & CONTROL_MASK;
        ADDR_ROUTING:  routing_d  = i_wdata & ROUTING_MASK;
        ADDR_BOOTFACT: bootfact_d = i_wdata & BOOTFACT_MASK;
        default: ;
      endcase
    end
    // Soft reset clears state on the next edge; the pulse reports it
    if (srst_q) begin
      control_d  = CONTROL_RST;
      routing_d  = ROUTING_RST;
      bootfact_d = BOOTFACT_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control_q  <= CONTROL_RST;
      routing_q  <= ROUTING_RST;
      bootfact_q <= BOOTFACT_RST;
    end else begin
      control_q  <= control_d;
      routing_q  <= routing_d;
      bootfact_q <= bootfact_d;
    end
  end

  // ----------------------------------------
  // Soft reset pulse
  // ----------------------------------------
  // One-cycle pulse; the register clear follows on the next edge
  always_comb begin
    srst_d = wr_hit_reset;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_d;
    end
  end

  // ----------------------------------------
  // Attachment tracking
  // ----------------------------------------
  // Manual routing waits on this flag
  always_comb begin
    attached_d = attached_q;
    if (i_detach_pulse) begin
      attached_d = 1'b0;
    end
    // Attach wins over a detach seen in the same cycle
    if (i_attach_pulse) begin
      attached_d = 1'b1;
    end
    // Soft reset wins over both
    if (srst_q) begin
      attached_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      attached_q <= 1'b0;
    end else begin
      attached_q <= attached_d;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read data holds until the next read; soft reset leaves it alone
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = i_rd_en;
    if (i_rd_en) begin
      case (i_addr)
        ADDR_CONTROL:  rdata_d = control_q;
        ADDR_ROUTING:  rdata_d = routing_q;
        ADDR_BOOTFACT: rdata_d = bootfact_q;
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------
  // Switch drive
  // ----------------------------------------
  logic [3:0] sw_d, sw_q;
  logic       boot_d, boot_q, fact_d, fact_q, fact_oe_d, fact_oe_q;
  logic [2:0] minus_code, plus_code;
  logic [2:0] line_code [2];

  always_comb begin
    minus_code = ROUTE_OPEN;
    plus_code  = ROUTE_OPEN;
    if (control_q[OPEN_BIT]) begin
      minus_code = ROUTE_OPEN;
      plus_code  = ROUTE_OPEN;
    end else if (control_q[AUTO_BIT]) begin
      minus_code = {1'b0, i_auto_minus_sel};
      plus_code  = {1'b0, i_auto_plus_sel};
    end else if (attached_q) begin
      minus_code = routing_q[MINUS_HI:MINUS_LO];
      plus_code  = routing_q[PLUS_HI:PLUS_LO];
    end
    boot_d  = bootfact_q[BOOT_BIT];
    if (FACTORY_ACTIVE_LOW) begin
      fact_d    = 1'b0;
      fact_oe_d = bootfact_q[FACT_BIT];
    end else begin
      fact_d    = bootfact_q[FACT_BIT];
      fact_oe_d = 1'b1;
    end
  end

  // One decoder per connector line, each fed only by its own code
  assign line_code[0] = minus_code;
  assign line_code[1] = plus_code;
  for (genvar ln = 0; ln < 2; ln++) begin : g_line
    // Unused codes leave the line open, the safe choice
    assign sw_d[2*ln]     = (line_code[ln] == ROUTE_USB);
    assign sw_d[2*ln + 1] = (line_code[ln] == ROUTE_UART);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_q      <= 4'h0;
      boot_q    <= 1'b0;
      fact_q    <= 1'b0;
      fact_oe_q <= 1'b0;
    end else begin
      sw_q      <= sw_d;
      boot_q    <= boot_d;
      fact_q    <= fact_d;
      fact_oe_q <= fact_oe_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_usb_path_minus_en      = sw_q[0];
  assign o_uart_path_minus_en     = sw_q[1];
  assign o_usb_path_plus_en       = sw_q[2];
  assign o_uart_path_plus_en      = sw_q[3];
  assign o_boot_level             = boot_q;
  assign o_factory_mode_output    = fact_q;
  assign o_factory_mode_output_oe = fact_oe_q;
  assign o_soft_reset             = srst_q;
  assign o_rdata                  = rdata_q;
  assign o_rvalid                 = rvalid_q;
endmodule
`default_nettype wire

/* core/usw_pkg.sv */
// What this block does
// - Minus-line field bits 7:5: 000 open, 001 USB path, 011 UART path.
// - Plus-line field bits 4:2: 000 open, 001 USB path, 011 UART path.
// - Manual routing applies only after an accessory has been attached.
// - Factory bit 2 set asserts the factory-mode output per variant polarity.
// - Factory bit 2 clear deasserts: released (open-drain) or driven low (push-pull).
// - Writing 1 to reset bit 0 clears control, routing, boot/factory and attach state (not read data); 0 does nothing.
// - With control bit 4 clear, bit 2 clear selects manual routing and set selects automatic switching; bit 4 set opens both lines.
package usw_pkg;
  localparam logic [7:0] ADDR_CONTROL  = 8'h02;
  localparam logic [7:0] ADDR_ROUTING  = 8'h13;
  localparam logic [7:0] ADDR_BOOTFACT = 8'h14;
  localparam logic [7:0] ADDR_SRESET   = 8'h1b;
  localparam int MINUS_HI   = 7;
  localparam int MINUS_LO   = 5;
  localparam int PLUS_HI    = 4;
  localparam int PLUS_LO    = 2;
  localparam int BOOT_BIT   = 3;
  localparam int FACT_BIT   = 2;
  localparam int AUTO_BIT   = 2;
  localparam int OPEN_BIT   = 4;
  localparam int SRST_BIT   = 0;
  localparam logic [2:0] ROUTE_OPEN = 3'h0;
  localparam logic [2:0] ROUTE_USB  = 3'h1;
  localparam logic [2:0] ROUTE_UART = 3'h3;
  localparam logic [7:0] ROUTING_RST  = 8'h00;
  localparam logic [7:0] BOOTFACT_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST  = 8'h05;
  localparam logic [7:0] CONTROL_MASK = 8'h15;
  localparam logic [7:0] ROUTING_MASK = 8'hfc;
  localparam logic [7:0] BOOTFACT_MASK = 8'h0c;
endpackage

/* verif/usw_switch_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module usw_switch_ctrl_monitor
  import usw_pkg::*;
#(
  parameter bit FACTORY_ACTIVE_LOW = 1'b1
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_attach_pulse,
  input  wire logic       i_detach_pulse,
  input  wire logic [1:0] i_auto_minus_sel,
  input  wire logic       o_usb_path_minus_en,
  input  wire logic       o_uart_path_minus_en,
  input  wire logic       o_usb_path_plus_en,
  input  wire logic       o_uart_path_plus_en,
  input  wire logic       o_boot_level,
  input  wire logic       o_factory_mode_output,
  input  wire logic       o_factory_mode_output_oe,
  input  wire logic       o_soft_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic seen_q;
  wire fon = FACTORY_ACTIVE_LOW ? o_factory_mode_output_oe : o_factory_mode_output;
  wire foff = FACTORY_ACTIVE_LOW ? !o_factory_mode_output_oe : !o_factory_mode_output;
  // Attach wins over a detach in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) seen_q <= 1'b0;
    else seen_q <= i_attach_pulse | (seen_q & ~i_detach_pulse & ~o_soft_reset);
  sequence s_wr(a, m, v);
    i_wr_en && i_addr == a && (i_wdata & m) == v;
  endsequence
  chk_minus_one_path: assert property (
    !(o_usb_path_minus_en && o_uart_path_minus_en)) else $error("minus both");
  chk_plus_one_path: assert property (
    !(o_usb_path_plus_en && o_uart_path_plus_en)) else $error("plus both");
  chk_route_needs_attach: assert property (
    o_usb_path_minus_en && $past(i_auto_minus_sel, 2) == 2'h0 |-> seen_q || $past(seen_q))
    else $error("route w/o attach");
  chk_factory_on: assert property (
    s_wr(ADDR_BOOTFACT, 8'h04, 8'h04) ##1 !i_wr_en |=> fon) else $error("factory on");
  chk_factory_off: assert property (
    s_wr(ADDR_BOOTFACT, 8'h04, 8'h00) ##1 !i_wr_en |=> foff) else $error("factory off");
  chk_sreset_pulse: assert property (
    s_wr(ADDR_SRESET, 8'h01, 8'h01) |-> ##1 o_soft_reset) else $error("no sreset");
  chk_sreset_none: assert property (
    s_wr(ADDR_SRESET, 8'h01, 8'h00) |-> ##1 !o_soft_reset) else $error("false sreset");
  chk_sreset_clears: assert property (
    o_soft_reset ##1 !i_wr_en [*2] |=> !o_boot_level) else $error("boot kept");
endmodule
bind usw_switch_ctrl usw_switch_ctrl_monitor #(.FACTORY_ACTIVE_LOW(FACTORY_ACTIVE_LOW)) mon (.*);
`default_nettype wire

/* verif/usw_host.sv */
`timescale 1ns/1ps
`default_nettype none
module usw_host (
  input  wire logic       i_clk,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial {o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk); #1;
    {o_addr, o_wdata, o_wr_en} = {a, d, 1'b1};
    @(posedge i_clk); #1;
    o_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk); #1;
    {o_addr, o_rd_en} = {a, 1'b1};
    @(posedge i_clk); #1;
    o_rd_en = 1'b0;
    d = i_rvalid ? i_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

/* verif/tb_usw_switch_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_usw_switch_ctrl;
  import usw_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       att = 1'b0;
  logic       det = 1'b0;
  logic [1:0] ams = 2'h0;
  logic [1:0] aps = 2'h0;
  logic       wr, rd, rv, bt, fo, foe, srst;
  logic [7:0] ad, wd, rdat, v, c;
  logic [3:0] en;
  int error_cnt = 0, checks_done = 0, seed = 73, i;
  logic [7:0] codes [4] = '{8'h24, 8'h6c, 8'h2c, 8'h44};
  usw_host host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr_en(wr), .o_rd_en(rd),
    .o_addr(ad), .o_wdata(wd));
  usw_switch_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr), .i_rd_en(rd), .i_addr(ad),
    .i_wdata(wd), .i_attach_pulse(att), .i_detach_pulse(det), .i_auto_minus_sel(ams),
    .i_auto_plus_sel(aps), .o_rdata(rdat), .o_rvalid(rv), .o_usb_path_minus_en(en[3]),
    .o_uart_path_minus_en(en[2]), .o_usb_path_plus_en(en[1]), .o_uart_path_plus_en(en[0]),
    .o_boot_level(bt), .o_factory_mode_output(fo), .o_factory_mode_output_oe(foe),
    .o_soft_reset(srst));
  initial forever #20 clk = ~clk;
  initial begin #100000; error_cnt++; tally_and_finish(); end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin error_cnt++; $display("unexpected %s exp %h seen %h", n, e, s); end
  endtask
  // Outputs follow a write two edges later
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic is_detach);
    @(posedge clk);
    #1;
    if (is_detach) det = 1'b1;
    else att = 1'b1;
    @(posedge clk);
    #1;
    {att, det} = 2'b00;
  endtask
  function automatic logic [7:0] route(input logic [7:0] c);
    return {4'h0, c[7:5] == 3'h1, c[7:5] == 3'h3, c[4:2] == 3'h1, c[4:2] == 3'h3};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.rd(ADDR_CONTROL, v);
    chk("ctrl", v, CONTROL_RST);
    host.rd(8'h30, v);
    chk("unmapped", v, 8'h00);
    host.wr(ADDR_CONTROL, 8'h00);
    host.wr(ADDR_ROUTING, 8'h24);
    settle();
    chk("en", {4'h0, en}, 8'h00);
    pulse(1'b0);
    for (i = 0; i < 4; i++) begin
      host.wr(ADDR_ROUTING, {ROUTE_OPEN, ROUTE_OPEN, 2'h0});
      settle();
      chk("open", {4'h0, en}, 8'h00);
      host.wr(ADDR_ROUTING, codes[i]);
      settle();
      chk("en", {4'h0, en}, route(codes[i]));
    end
    host.rd(ADDR_ROUTING, v);
    chk("rd route", v, codes[3]);
    for (i = 0; i < 6; i++) begin
      v = (8'($random(seed)) & 8'h08) | (i[0] ? 8'h04 : 8'h00);
      host.wr(ADDR_BOOTFACT, v);
      settle();
      chk("fact", {5'h0, bt, fo, foe}, {5'h0, v[BOOT_BIT], 1'b0, v[FACT_BIT]});
    end
    host.wr(ADDR_SRESET, 8'h00);
    chk("no sreset", {7'h0, srst}, 8'h00);
    settle();
    chk("keep", {4'h0, en}, route(codes[3]));
    pulse(1'b1);
    settle();
    chk("detach", {4'h0, en}, 8'h00);
    host.wr(ADDR_BOOTFACT, 8'h08);
    host.wr(ADDR_SRESET, 8'h01);
    chk("sreset", {7'h0, srst}, 8'h01);
    settle();
    chk("boot", {7'h0, bt}, 8'h00);
    host.rd(ADDR_ROUTING, v);
    chk("route", v, ROUTING_RST);
    pulse(1'b0);
    ams = 2'($random(seed));
    aps = 2'($random(seed));
    c = {1'b0, ams, 1'b0, aps, 2'h0};
    host.wr(ADDR_ROUTING, 8'h24);
    settle();
    chk("auto", {4'h0, en}, route(c));
    host.wr(ADDR_CONTROL, CONTROL_RST | (8'h01 << OPEN_BIT));
    settle();
    chk("all open", {4'h0, en}, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
